// ==== hdl/sbt_mem_ctrl.sv ====
// Memory controller end: register slave, bank timing and burst transfer
`timescale 1ns/1ns
module sbt_mem_ctrl
  import sbt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  sbt_link_if.ctrl         link
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_CHECK = 2'h1,
    ST_LAT   = 2'h2,
    ST_XFER  = 2'h3
  } sbt_state_type;

  // ==========================================================
  // State
  logic [7:0]    awaddr_r, araddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]    bresp_r, rresp_r;
  logic [31:0]   rdata_r;
  logic [31:0]   cfg_r;
  logic [15:0]   mask_r;
  logic [31:0]   data_r [0:3];
  logic          refused_r, reinit_r;
  sbt_state_type state_r, state_nxt;
  sbt_cmd_type   op_r, cmd_r;
  logic [2:0]    bank_r, cmd_bank_r;
  logic [12:0]   addr_r, cmd_addr_r;
  logic [4:0]    lat_cnt_r;
  logic [1:0]    beat_r;
  logic [31:0]   wdq_r;
  logic [3:0]    wmask_r;
  logic          wstrobe_r;
  logic [7:0]    open_r;
  logic [12:0]   row_r  [0:BANKS-1];
  logic [5:0]    ras_r  [0:BANKS-1];
  logic [5:0]    rc_r   [0:BANKS-1];
  logic [5:0]    rp_r   [0:BANKS-1];
  logic [5:0]    pblk_r [0:BANKS-1];

  function automatic logic [5:0] dec(logic [5:0] v);
    return (v == 6'h0) ? 6'h0 : v - 6'h1;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // ==========================================================
  // Register decode
  wire        wr_go   = !awready_r && !wready_r && !bvalid_r;
  wire [7:0]  wa      = {awaddr_r[7:2], 2'h0};
  wire        w_ok    = awaddr_r[7:5] == 3'h0;
  wire        w_cmd   = wr_go && wa == REG_CMD;
  wire        w_stat  = wr_go && wa == REG_STATUS;
  wire        w_cfg   = wr_go && wa == REG_CONFIG;
  wire        w_mask  = wr_go && wa == REG_MASK;
  wire        w_data  = wr_go && w_ok && awaddr_r[4];
  wire        busy    = state_r != ST_IDLE;
  wire        cmd_go  = w_cmd && !busy;
  wire [7:0]  ra      = {araddr_r[7:2], 2'h0};
  wire        r_ok    = araddr_r[7:5] == 3'h0;
  wire [31:0] stat_w  = {30'h0, refused_r, busy};
  wire [31:0] rd_mux  = (ra == REG_STATUS) ? stat_w :
                        (ra == REG_CONFIG) ? cfg_r :
                        (ra == REG_MASK)   ? {16'h0, mask_r} :
                        araddr_r[4]        ? data_r[araddr_r[3:2]] : 32'h0;

  // ==========================================================
  // Bank timing checks for the current bank
  wire [3:0] alat    = cfg_r[CFG_ADD_LSB +: 4];
  wire [3:0] rlat    = cfg_r[CFG_RCOL_LSB +: 4];
  wire [3:0] wlat    = cfg_r[CFG_WCOL_LSB +: 4];
  wire       op_rd   = op_r == SBT_CMD_RD;
  wire       op_wr   = op_r == SBT_CMD_WR;
  wire       op_col  = op_rd || op_wr;
  wire       len8    = sbt_is_len8(cfg_r[CFG_BL_LSB +: 2], addr_r[BURST_SEL_BIT]);
  wire [1:0] last    = len8 ? 2'(L8_NCK - 1) : 2'(L4_NCK - 1);
  wire [5:0] nclk    = len8 ? 6'(L8_NCK) : 6'(L4_NCK);
  wire       autop   = addr_r[AUTO_PRE_BIT];
  wire [4:0] lat     = op_rd ? 5'(alat) + 5'(rlat) : 5'(alat) + 5'(wlat);
  wire [5:0] pblk_v  = op_rd ? 6'(alat) + 6'(RTP_CYC) : 6'(alat) + 6'(wlat) + nclk + 6'(WR_CYC);
  wire       is_open = open_r[bank_r];
  wire       same    = row_r[bank_r] == addr_r;
  wire       chk     = state_r == ST_CHECK;
  wire       can_pre = ras_r[bank_r] == 6'h0 && pblk_r[bank_r] == 6'h0;
  wire       can_act = rp_r[bank_r] == 6'h0 && rc_r[bank_r] == 6'h0;
  wire       pre_op  = op_r == SBT_CMD_PRE;
  wire       act_op  = op_r == SBT_CMD_ACT;
  wire       do_pre  = chk && can_pre && (pre_op || (act_op && is_open && !same));
  wire       do_act  = chk && can_act && act_op && !is_open;
  wire       do_col  = chk && op_col && is_open;
  wire       bad     = chk && ((op_col && !is_open) || !(op_col || pre_op || act_op));
  wire       chk_end = do_act || (do_pre && pre_op) || bad || (chk && act_op && is_open && same);
  wire       enter_x = state_r == ST_LAT && lat_cnt_r == 5'h0;
  wire       in_x    = state_r == ST_XFER;
  wire       x_step  = in_x && (op_wr || link.rstrobe);
  wire       x_end   = x_step && beat_r == last;
  wire       next_w  = op_wr && (enter_x || (in_x && beat_r != last));
  wire [1:0] wbeat   = enter_x ? 2'h0 : beat_r + 2'h1;

  // Transfer sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (cmd_go) state_nxt = ST_CHECK;
      ST_CHECK: if (do_col) state_nxt = ST_LAT; else if (chk_end) state_nxt = ST_IDLE;
      ST_LAT:   if (lat_cnt_r == 5'h0) state_nxt = ST_XFER;
      ST_XFER:  if (x_end) state_nxt = ST_IDLE;
    endcase
  end

  // Per-bank open row and countdown timers
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    wire sel = bank_r == 3'(b);
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        open_r[b] <= 1'b0;
        row_r[b]  <= 13'h0;
        ras_r[b]  <= 6'h0;
        rc_r[b]   <= 6'h0;
        rp_r[b]   <= 6'h0;
        pblk_r[b] <= 6'h0;
      end else if (reinit_r) begin
        open_r[b] <= 1'b0;
      end else begin
        open_r[b] <= sel && do_act ? 1'b1 : sel && (do_pre || (do_col && autop)) ? 1'b0
                   : open_r[b];
        row_r[b]  <= sel && do_act ? addr_r : row_r[b];
        ras_r[b]  <= sel && do_act ? 6'(RAS_CYC) : dec(ras_r[b]);
        rc_r[b]   <= sel && do_act ? 6'(RC_CYC) : dec(rc_r[b]);
        rp_r[b]   <= sel && do_pre ? 6'(RP_CYC) : sel && do_col && autop
                   ? pblk_v + 6'(RP_CYC) : dec(rp_r[b]);
        pblk_r[b] <= sel && do_col ? pblk_v : dec(pblk_r[b]);
      end
    end
  end

  // Command engine and link drive
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_IDLE;
      op_r       <= SBT_CMD_NOP;
      bank_r     <= 3'h0;
      addr_r     <= 13'h0;
      cmd_r      <= SBT_CMD_NOP;
      cmd_bank_r <= 3'h0;
      cmd_addr_r <= 13'h0;
      lat_cnt_r  <= 5'h0;
      beat_r     <= 2'h0;
      wdq_r      <= 32'h0;
      wmask_r    <= 4'h0;
      wstrobe_r  <= 1'b0;
    end else begin
      state_r    <= reinit_r ? ST_IDLE : state_nxt;
      if (cmd_go) begin
        op_r   <= sbt_cmd_type'(wdata_r[CMD_OP_LSB +: 3]);
        bank_r <= wdata_r[CMD_BANK_LSB +: 3];
        addr_r <= wdata_r[CMD_ADDR_LSB +: 13];
      end
      cmd_r      <= do_pre ? SBT_CMD_PRE : do_act ? SBT_CMD_ACT : do_col ? op_r : SBT_CMD_NOP;
      cmd_bank_r <= bank_r;
      cmd_addr_r <= addr_r;
      lat_cnt_r  <= do_col ? lat : (lat_cnt_r == 5'h0 ? 5'h0 : lat_cnt_r - 5'h1);
      beat_r     <= enter_x ? 2'h0 : x_step ? beat_r + 2'h1 : beat_r;
      wstrobe_r  <= next_w;
      wdq_r      <= next_w ? data_r[wbeat] : 32'h0;
      wmask_r    <= next_w ? mask_r[4*wbeat +: 4] : 4'h0;
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
      awaddr_r  <= 8'h0;
      araddr_r  <= 8'h0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
      if (s_axi_arvalid && arready_r) begin
        araddr_r  <= s_axi_araddr;
        arready_r <= 1'b0;
      end else if (!arready_r && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= r_ok ? rd_mux : 32'h0;
        rresp_r  <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Software registers and read capture
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r     <= CFG_RST;
      mask_r    <= MASK_RST;
      refused_r <= 1'b0;
      reinit_r  <= 1'b0;
      for (int k = 0; k < 4; k++) data_r[k] <= 32'h0;
    end else begin
      if (w_cfg) cfg_r <= merge(cfg_r, wdata_r, wstrb_r) & 32'h0000_3fff;
      if (w_mask) mask_r <= 16'(merge({16'h0, mask_r}, wdata_r, wstrb_r));
      if (w_data) data_r[awaddr_r[3:2]] <= merge(data_r[awaddr_r[3:2]], wdata_r, wstrb_r);
      else if (in_x && op_rd && link.rstrobe) data_r[beat_r] <= link.rdq;
      // A new refusal wins over a clear in the same cycle
      if ((w_cmd && busy) || bad) refused_r <= 1'b1;
      else if (w_stat && wstrb_r[0] && wdata_r[STAT_REF_BIT]) refused_r <= 1'b0;
      reinit_r <= w_cfg && wstrb_r[1] && wdata_r[CFG_REINIT_BIT];
    end
  end

  assign s_axi_awready             = awready_r;
  assign s_axi_wready              = wready_r;
  assign s_axi_bvalid              = bvalid_r;
  assign s_axi_bresp               = bresp_r;
  assign s_axi_arready             = arready_r;
  assign s_axi_rvalid              = rvalid_r;
  assign s_axi_rresp               = rresp_r;
  assign s_axi_rdata               = rdata_r;
  assign link.mem_reset_n          = !reinit_r;
  assign link.cmd                  = cmd_r;
  assign link.bank                 = cmd_bank_r;
  assign link.addr                 = cmd_addr_r;
  assign link.mode_bl              = cfg_r[CFG_BL_LSB +: 2];
  assign link.additive_latency     = alat;
  assign link.read_column_latency  = rlat;
  assign link.write_column_latency = wlat;
  assign link.wdq                  = wdq_r;
  assign link.write_byte_mask      = wmask_r;
  assign link.wstrobe              = wstrobe_r;

endmodule // sbt_mem_ctrl

// ==== hdl/sbt_pkg.sv ====
// Shared constants and types for the burst timing link
package sbt_pkg;

  // ==========================================================
  // Clock and timing
  localparam real CLK_NS      = 100.0;
  localparam real RTP_NS      = 7.5;
  localparam int  RTP_MIN_NCK = 4;
  localparam real RAS_NS      = 35.0;
  localparam real RP_NS       = 13.75;
  localparam real RC_NS       = 48.75;
  localparam real WR_NS       = 15.0;

  // Least time in cycles, rounded up, never below one
  function automatic int sbt_cyc(real ns);
    int c;
    c = int'($ceil(ns / CLK_NS));
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RTP_CYC = (sbt_cyc(RTP_NS) > RTP_MIN_NCK) ? sbt_cyc(RTP_NS) : RTP_MIN_NCK;
  localparam int RAS_CYC = sbt_cyc(RAS_NS);
  localparam int RP_CYC  = sbt_cyc(RP_NS);
  localparam int RC_CYC  = sbt_cyc(RC_NS);
  localparam int WR_CYC  = sbt_cyc(WR_NS);
  localparam int CCD_NCK = 4;
  localparam int L8_NCK  = 4;
  localparam int L4_NCK  = 2;

  // ==========================================================
  // Sizes and address fields
  localparam int BANKS         = 8;
  localparam int PIPE_D        = 32;
  localparam int MEM_D         = 256;
  localparam int BURST_SEL_BIT = 12;
  localparam int AUTO_PRE_BIT  = 10;
  localparam int COL_LO        = 2;
  localparam int COL_HI        = 4;

  // Burst length field of mode register zero
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;

  typedef enum logic [2:0] {
    SBT_CMD_NOP = 3'h0,
    SBT_CMD_ACT = 3'h1,
    SBT_CMD_RD  = 3'h2,
    SBT_CMD_WR  = 3'h3,
    SBT_CMD_PRE = 3'h4
  } sbt_cmd_type;

  // ==========================================================
  // Controller registers
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_MASK   = 8'h0c;
  localparam logic [7:0] REG_DATA0  = 8'h10;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_BANK_LSB   = 3;
  localparam int CMD_ADDR_LSB   = 6;
  localparam int CFG_BL_LSB     = 0;
  localparam int CFG_ADD_LSB    = 2;
  localparam int CFG_RCOL_LSB   = 6;
  localparam int CFG_WCOL_LSB   = 10;
  localparam int CFG_REINIT_BIT = 14;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_REF_BIT   = 1;
  localparam logic [31:0] CFG_RST  = 32'h0000_1581;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Eight beats when fixed, or on the fly with the select bit high
  function automatic logic sbt_is_len8(logic [1:0] bl, logic sel);
    return (bl == BL_FIXED8) || ((bl == BL_OTF) && sel);
  endfunction

endpackage

// ==== hdl/sbt_link_if.sv ====
// Command and data link between memory controller and burst device
`timescale 1ns/1ns
interface sbt_link_if;
  import sbt_pkg::*;

  logic        mem_reset_n;
  sbt_cmd_type cmd;
  logic [2:0]  bank;
  logic [12:0] addr;
  logic [1:0]  mode_bl;
  logic [3:0]  additive_latency;
  logic [3:0]  read_column_latency;
  logic [3:0]  write_column_latency;
  logic [31:0] wdq;
  logic [3:0]  write_byte_mask;
  logic        wstrobe;
  logic [31:0] rdq;
  logic        rstrobe;

  modport device (
    input  mem_reset_n, cmd, bank, addr, mode_bl, additive_latency,
    input  read_column_latency, write_column_latency, wdq, write_byte_mask, wstrobe,
    output rdq, rstrobe
  );

  modport ctrl (
    output mem_reset_n, cmd, bank, addr, mode_bl, additive_latency,
    output read_column_latency, write_column_latency, wdq, write_byte_mask, wstrobe,
    input  rdq, rstrobe
  );
endinterface

// ==== hdl/sbt_mem_device.sv ====
// Burst device end: latency pipeline, burst engine and storage array
`timescale 1ns/1ns
module sbt_mem_device
  import sbt_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   reset_n,
  sbt_link_if.device  link,
  output logic        wr_beat_dropped
);

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       len8;
    logic [2:0] bank;
    logic [2:0] col;
  } sbt_pend_type;

  // ==========================================================
  // Storage and state
  logic [15:0]  mem_r    [0:MEM_D-1];
  sbt_pend_type pipe_r   [0:PIPE_D-1];
  sbt_pend_type pipe_nxt [0:PIPE_D-1];
  sbt_pend_type new_pend;
  sbt_pend_type bst_r;
  logic         bact_r;
  logic [1:0]   bclk_r;
  logic [31:0]  rdq_r;
  logic         rstrobe_r;
  logic         drop_r;

  // Keep old byte where the mask bit is high
  function automatic logic [15:0] keep_masked(logic [15:0] old, logic [15:0] nw,
                                              logic [1:0] m);
    return {m[1] ? old[15:8] : nw[15:8], m[0] ? old[7:0] : nw[7:0]};
  endfunction

  // ==========================================================
  // Command decode
  wire       is_rd   = link.cmd == SBT_CMD_RD;
  wire       is_wr   = link.cmd == SBT_CMD_WR;
  wire [4:0] rd_lat  = {1'b0, link.additive_latency} + {1'b0, link.read_column_latency};
  wire [4:0] wr_lat  = {1'b0, link.additive_latency} + {1'b0, link.write_column_latency};
  wire [4:0] lat     = is_rd ? rd_lat : wr_lat;
  wire [4:0] ins_idx = lat - 5'h1;
  assign new_pend.rd   = is_rd;
  assign new_pend.wr   = is_wr;
  assign new_pend.len8 = sbt_is_len8(link.mode_bl, link.addr[BURST_SEL_BIT]);
  assign new_pend.bank = link.bank;
  assign new_pend.col  = link.addr[COL_HI:COL_LO];

  // Latency line: each read or write drops in at its latency and walks down
  for (genvar i = 0; i < PIPE_D; i++) begin : g_pipe
    if (i == PIPE_D - 1) begin : g_tail
      assign pipe_nxt[i] = ((is_rd || is_wr) && ins_idx == 5'(i)) ? new_pend : '0;
    end else begin : g_body
      assign pipe_nxt[i] = ((is_rd || is_wr) && ins_idx == 5'(i)) ? new_pend : pipe_r[i+1];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < PIPE_D; k++) pipe_r[k] <= '0;
    end else if (!link.mem_reset_n) begin
      for (int k = 0; k < PIPE_D; k++) pipe_r[k] <= '0;
    end else begin
      for (int k = 0; k < PIPE_D; k++) pipe_r[k] <= pipe_nxt[k];
    end
  end

  // ==========================================================
  // Burst engine: two beats per clock, four clocks or two
  wire [1:0] blast   = bst_r.len8 ? 2'(L8_NCK - 1) : 2'(L4_NCK - 1);
  wire [7:0] beat0   = {bst_r.bank, bst_r.col[2:1], bst_r.col[0] ^ bclk_r[1], bclk_r[0], 1'b0};
  wire [7:0] beat1   = beat0 | 8'h01;
  wire       reading = bact_r && bst_r.rd;
  wire       wr_now  = bact_r && bst_r.wr && link.wstrobe;
  wire       wr_miss = bact_r && bst_r.wr && !link.wstrobe;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bst_r  <= '0;
      bact_r <= 1'b0;
      bclk_r <= 2'h0;
    end else if (!link.mem_reset_n) begin
      bact_r <= 1'b0;
      bclk_r <= 2'h0;
    end else if (pipe_r[0].rd || pipe_r[0].wr) begin
      bst_r  <= pipe_r[0];
      bact_r <= 1'b1;
      bclk_r <= 2'h0;
    end else if (bact_r) begin
      bact_r <= bclk_r != blast;
      bclk_r <= bclk_r + 2'h1;
    end
  end

  // Array write; a missing strobe skips only that clock's two beats
  always_ff @(posedge core_clk) begin
    if (wr_now) begin
      mem_r[beat0] <= keep_masked(mem_r[beat0], link.wdq[15:0], link.write_byte_mask[1:0]);
      mem_r[beat1] <= keep_masked(mem_r[beat1], link.wdq[31:16], link.write_byte_mask[3:2]);
    end
  end

  // Read return; the byte mask plays no part here
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdq_r     <= 32'h0;
      rstrobe_r <= 1'b0;
      drop_r    <= 1'b0;
    end else begin
      rdq_r     <= reading ? {mem_r[beat1], mem_r[beat0]} : 32'h0;
      rstrobe_r <= reading;
      drop_r    <= wr_miss;
    end
  end

  assign link.rdq     = rdq_r;
  assign link.rstrobe = rstrobe_r;
  assign wr_beat_dropped = drop_r;

endmodule // sbt_mem_device

// ==== test/sbt_link_asserts.sv ====
// Assertions on the burst link between controller and device
`timescale 1ns/1ns
module sbt_link_asserts
  import sbt_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        mem_reset_n,
  input wire sbt_cmd_type cmd,
  input wire logic [12:0] addr,
  input wire logic [1:0]  mode_bl,
  input wire logic [3:0]  additive_latency,
  input wire logic [3:0]  read_column_latency,
  input wire logic [3:0]  write_column_latency,
  input wire logic [31:0] wdq,
  input wire logic        wstrobe,
  input wire logic        rstrobe
);
  // ==========================================================
  // Countdown to first data clock, burst length decode
  logic [5:0] wcnt_r, rcnt_r;
  wire logic [5:0] wcnt_nxt = (cmd == SBT_CMD_WR) ?
    6'(additive_latency) + 6'(write_column_latency) : wcnt_r - 6'(wcnt_r != 6'h0);
  wire logic [5:0] rcnt_nxt = (cmd == SBT_CMD_RD) ?
    6'(additive_latency) + 6'(read_column_latency) + 6'h1 : rcnt_r - 6'(rcnt_r != 6'h0);
  wire logic col_w = (cmd == SBT_CMD_RD) || (cmd == SBT_CMD_WR);
  wire logic eight_w = (mode_bl == BL_FIXED8) || ((mode_bl == BL_OTF) && addr[BURST_SEL_BIT]);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_r <= 6'h0;
      rcnt_r <= 6'h0;
    end else begin
      wcnt_r <= wcnt_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_four(sig); sig [*4] ##1 !sig; endsequence
  sequence s_two(sig); sig [*2] ##1 !sig; endsequence
  property p_col_gap; col_w |=> (!col_w) [*3]; endproperty
  property p_rd_pre; cmd == SBT_CMD_RD |=> (cmd != SBT_CMD_PRE) [*3]; endproperty
  property p_wr_lat; wcnt_r == 6'h1 |=> $rose(wstrobe); endproperty
  property p_rd_lat; rcnt_r == 6'h1 |=> $rose(rstrobe); endproperty
  property p_wr_len8; $rose(wstrobe) && eight_w |-> s_four(wstrobe); endproperty
  property p_wr_len4; $rose(wstrobe) && !eight_w |-> s_two(wstrobe); endproperty
  property p_rd_len8; $rose(rstrobe) && eight_w |-> s_four(rstrobe); endproperty
  property p_rd_len4; $rose(rstrobe) && !eight_w |-> s_two(rstrobe); endproperty
  property p_wr_idle; !wstrobe |-> wdq == 32'h0; endproperty
  property p_reinit; !mem_reset_n |=> mem_reset_n; endproperty
  a_col_gap: assert property (p_col_gap) else $error("column gap");
  a_rd_pre: assert property (p_rd_pre) else $error("early precharge");
  a_wr_lat: assert property (p_wr_lat) else $error("write latency");
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
  a_wr_len8: assert property (p_wr_len8) else $error("write length 8");
  a_wr_len4: assert property (p_wr_len4) else $error("write length 4");
  a_rd_len8: assert property (p_rd_len8) else $error("read length 8");
  a_rd_len4: assert property (p_rd_len4) else $error("read length 4");
  a_wr_idle: assert property (p_wr_idle) else $error("data outside burst");
  a_reinit: assert property (p_reinit) else $error("reinit width");
endmodule // sbt_link_asserts

// ==== test/sdram_burst_access_timing_tb.sv ====
// Bench: controller and device back to back, driven over AXI4-Lite
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module sdram_burst_access_timing_tb
  import sbt_pkg::*;
;
  logic        core_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [34:0] notes[$];
  logic [34:0] note;
  int          failures = 0, n_compared = 0;
  logic        dropped_w, dropped_seen = 1'b0;
  always #50 core_clk = ~core_clk;
  sbt_link_if u_sbt_link_if ();
  sbt_mem_ctrl u_sbt_mem_ctrl (.*, .link(u_sbt_link_if));
  sbt_mem_device u_sbt_mem_device (.core_clk(core_clk), .reset_n(reset_n),
    .link(u_sbt_link_if), .wr_beat_dropped(dropped_w));
  // Latch any dropped write beat for the closing check
  always @(posedge core_clk) if (dropped_w === 1'b1) dropped_seen <= 1'b1;
  sbt_link_asserts u_sbt_link_asserts (.core_clk(core_clk), .reset_n(reset_n),
    .mem_reset_n(u_sbt_link_if.mem_reset_n), .cmd(u_sbt_link_if.cmd),
    .addr(u_sbt_link_if.addr), .mode_bl(u_sbt_link_if.mode_bl),
    .additive_latency(u_sbt_link_if.additive_latency),
    .read_column_latency(u_sbt_link_if.read_column_latency),
    .write_column_latency(u_sbt_link_if.write_column_latency),
    .wdq(u_sbt_link_if.wdq), .wstrobe(u_sbt_link_if.wstrobe), .rstrobe(u_sbt_link_if.rstrobe));
  // ==========================================================
  // Answer monitor: oldest note against each response
  always @(posedge core_clk) begin
    if (notes.size() > 0 && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
      note = notes.pop_front();
      if (note[34]) `CHK(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, note[33:0])
    end
  end
  task automatic print_verdict;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    notes.push_back({1'b1, RESP_OKAY, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
    if (n == 99) begin failures++; print_verdict(); end
  endtask
  task automatic axr(input logic [7:0] a, input logic [34:0] e, output logic [31:0] d);
    int n;
    notes.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    if (n == 99) begin failures++; print_verdict(); end
  endtask
  // Command write, then poll until the engine is idle
  task automatic issue(input logic [2:0] op, input logic [2:0] bk, input logic [12:0] ad);
    logic [31:0] s;
    int i;
    axw(REG_CMD, {13'h0, ad, bk, op}, 4'hf);
    for (i = 0; i < 40; i++) begin
      axr(REG_STATUS, 35'h0, s);
      if (s[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 40) begin failures++; print_verdict(); end
  endtask
  task automatic fill(input logic [31:0] v [4]);
    int k;
    for (k = 0; k < 4; k++) axw(REG_DATA0 + 8'(4 * k), v[k], 4'hf);
  endtask
  // Five burst length cases, masked overwrite, read back
  initial begin
    logic [31:0] a_w [4], b_w [4], c_w [4], ex, rd_v;
    logic [15:0] msk;
    logic [12:0] row, ad;
    logic [3:0]  alat;
    logic [1:0]  bl;
    int          m, k, j;
    void'($urandom(32'hb116));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    axr(REG_CONFIG, {1'b1, RESP_OKAY, CFG_RST}, rd_v);
    axr(8'he0, {1'b1, RESP_SLVERR, 32'h0}, rd_v);
    for (m = 0; m < 5; m++) begin
      bl = (m == 0) ? 2'h0 : (m < 3) ? 2'h1 : 2'(m - 1);
      alat = 4'($urandom_range(0, 2));
      row = 13'($urandom);
      msk = 16'($urandom);
      ad = {m[0], 1'b0, 1'b0, 5'h0, 2'($urandom), 3'h0};
      for (k = 0; k < 4; k++) begin
        a_w[k] = $urandom;
        b_w[k] = $urandom;
        c_w[k] = ~b_w[k];
      end
      axw(REG_CONFIG, {18'h0, 4'h5, 4'h6, alat, bl}, 4'hf);
      issue(SBT_CMD_ACT, m[2:0], row);
      fill(a_w);
      axw(REG_MASK, 32'h0, 4'h3);
      issue(SBT_CMD_WR, m[2:0], ad);
      fill(b_w);
      axw(REG_MASK, {16'h0, msk}, 4'h3);
      issue(SBT_CMD_WR, m[2:0], ad);
      fill(c_w);
      issue(SBT_CMD_RD, m[2:0], ad | {2'h0, m[0], 10'h0});
      for (k = 0; k < ((m < 2) ? 4 : 2); k++) begin
        for (j = 0; j < 4; j++) ex[8*j +: 8] = msk[4*k+j] ? a_w[k][8*j +: 8] : b_w[k][8*j +: 8];
        axr(REG_DATA0 + 8'(4 * k), {1'b1, RESP_OKAY, ex}, rd_v);
      end
      if (!m[0]) issue(SBT_CMD_ACT, m[2:0], row ^ 13'h1);
    end
    issue(SBT_CMD_RD, 3'h7, 13'h0);
    axr(REG_STATUS, {1'b1, RESP_OKAY, 32'h2}, rd_v);
    axw(REG_STATUS, 32'h2, 4'h1);
    axr(REG_STATUS, {1'b1, RESP_OKAY, 32'h0}, rd_v);
    axw(REG_CONFIG, CFG_RST | 32'h4000, 4'hf);
    axr(REG_CONFIG, {1'b1, RESP_OKAY, CFG_RST}, rd_v);
    repeat (4) @(posedge core_clk);
    `CHK(dropped_seen, 1'b0)
    print_verdict();
  end
endmodule // sdram_burst_access_timing_tb
